// file: verilog/bfs_regs.svh
// constants for the breaker failure supervisor
`ifndef BFS_REGS_SVH
`define BFS_REGS_SVH
`define BFS_DELAY_W 24
`define BFS_DELAY_DEFAULT 24'd1000
`define BFS_NUM_SRC 8
`define BFS_NUM_EXTRA 3
`endif

// file: verilog/bfs_pkg.sv
// types for the breaker failure supervisor
package bfs_pkg;
  typedef enum logic [1:0] {
    BFS_SCH_POS,
    BFS_SCH_CUR,
    BFS_SCH_BOTH
  } bfs_scheme_t;
  typedef enum logic [1:0] {
    BFS_TRG_ALL,
    BFS_TRG_CURRENT,
    BFS_TRG_EXTERNAL,
    BFS_TRG_NONE
  } bfs_trig_mode_t;
  typedef struct packed {
    logic breaker_closed;
    logic breaker_open;
    logic undercurrent;
  } bfs_breaker_t;
endpackage

// file: verilog/bfs_sync.sv
// two-flop synchroniser for one pin level
`timescale 1ns/10ps
module bfs_sync (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic d, // asynchronous level
  output logic q // synchronised level
);
  logic meta_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // bfs_sync

// file: verilog/bfs_timer.sv
// failure delay timer: counts cycles up to a delay
`timescale 1ns/10ps
`include "bfs_regs.svh"
module bfs_timer #(
  parameter int W = `BFS_DELAY_W
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic run, // count while high, clear while low
  input wire logic [W-1:0] delay, // cycles to expiry
  output logic expired // high once count reaches delay
);
  logic [W-1:0] cnt_r;
  // expiry flags exactly when count equals delay
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (!run) begin
      cnt_r <= '0;
    end else if (cnt_r != delay) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  assign expired = run && (cnt_r == delay);
endmodule // bfs_timer

// file: verilog/bfs_supervisor.sv
// breaker failure supervisor top level
`timescale 1ns/10ps
`include "bfs_regs.svh"
module bfs_supervisor #(
  parameter int N_SRC = `BFS_NUM_SRC,
  parameter int N_EXTRA = `BFS_NUM_EXTRA,
  parameter int DW = `BFS_DELAY_W
) (
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic rst, // async reset, active high
  input wire logic in_use, // module enabled
  input bfs_pkg::bfs_scheme_t scheme, // supervision scheme
  input bfs_pkg::bfs_trig_mode_t trig_mode, // trigger mode
  input wire logic [DW-1:0] fail_delay, // timer delay in cycles
  input wire logic [N_SRC-1:0] trip_in, // trip sources, async
  input wire logic [N_SRC-1:0] trip_mapped, // source mapped onto this breaker
  input wire logic [N_SRC-1:0] trip_is_current, // source is a current trip
  input wire logic [N_EXTRA-1:0] extra_trigger_input, // extra triggers, async
  input bfs_pkg::bfs_breaker_t brk_in, // breaker position and current, async
  input wire logic lockout_reset, // clears latched failure
  output logic upstream_trip_r, // trip to upstream breaker
  output logic failure_latched_r, // latched failure, blocks closing
  output logic timer_running_r, // supervisor active
  output logic rejected_r // supervisor rejected
);
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_ACTIVE,
    ST_REJECTED,
    ST_FAILED
  } bfs_state_t;

  // ==========================================================
  // input synchronisers
  // ==========================================================
  localparam int NS = N_SRC + N_EXTRA + 3;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  assign raw_in = {trip_in, extra_trigger_input, brk_in};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      bfs_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(raw_in[gi]),
        .q(syn[gi])
      );
    end
  endgenerate

  logic [N_SRC-1:0] trip_s;
  logic [N_EXTRA-1:0] extra_s;
  bfs_pkg::bfs_breaker_t brk_s;
  assign trip_s = syn[NS-1 -: N_SRC];
  assign extra_s = syn[3 +: N_EXTRA];
  assign brk_s = syn[2:0];

  // ==========================================================
  // trigger qualification
  // ==========================================================
  logic [N_SRC-1:0] mode_mask;
  logic trig_any;
  always_comb begin
    unique case (trig_mode)
      bfs_pkg::BFS_TRG_ALL: mode_mask = {N_SRC{1'b1}};
      bfs_pkg::BFS_TRG_CURRENT: mode_mask = trip_is_current;
      bfs_pkg::BFS_TRG_EXTERNAL: mode_mask = ~trip_is_current;
      bfs_pkg::BFS_TRG_NONE: mode_mask = '0;
    endcase
  end
  // only mapped trips pass; extra inputs bypass the mapping
  assign trig_any = |(trip_s & trip_mapped & mode_mask) | (|extra_s);

  // ==========================================================
  // start and stop conditions per scheme
  // ==========================================================
  logic start_ok;
  logic open_evidence;
  always_comb begin
    unique case (scheme)
      bfs_pkg::BFS_SCH_POS: begin
        start_ok = trig_any && brk_s.breaker_closed;
        open_evidence = brk_s.breaker_open;
      end
      bfs_pkg::BFS_SCH_CUR: begin
        start_ok = trig_any;
        open_evidence = brk_s.undercurrent;
      end
      bfs_pkg::BFS_SCH_BOTH: begin
        start_ok = trig_any && brk_s.breaker_closed;
        open_evidence = brk_s.breaker_open && brk_s.undercurrent;
      end
      default: begin
        start_ok = 1'b0;
        open_evidence = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // state machine
  // ==========================================================
  bfs_state_t state_r;
  logic expired;
  logic run;
  assign run = (state_r == ST_ACTIVE) && !open_evidence && in_use;

  bfs_timer #(.W(DW)) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(run),
    .delay(fail_delay),
    .expired(expired)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_STANDBY;
    end else if (!in_use) begin
      state_r <= ST_STANDBY;
    end else begin
      unique case (state_r)
        ST_STANDBY: if (start_ok) state_r <= ST_ACTIVE;
        ST_ACTIVE: begin
          // stop has priority over a same-cycle expiry: breaker proved open
          if (open_evidence) state_r <= ST_REJECTED;
          else if (expired) state_r <= ST_FAILED;
        end
        ST_REJECTED: if (!trig_any) state_r <= ST_STANDBY;
        ST_FAILED: if (open_evidence && !trig_any) state_r <= ST_STANDBY;
      endcase
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upstream_trip_r <= 1'b0;
      timer_running_r <= 1'b0;
      rejected_r <= 1'b0;
    end else begin
      upstream_trip_r <= in_use && (state_r == ST_FAILED || (state_r == ST_ACTIVE && expired && !open_evidence))
                         && !(state_r == ST_FAILED && open_evidence && !trig_any);
      timer_running_r <= run;
      rejected_r <= in_use && (state_r == ST_REJECTED || (state_r == ST_ACTIVE && open_evidence));
    end
  end

  // latch survives trip drop; set wins over a same-cycle reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      failure_latched_r <= 1'b0;
    end else if (in_use && state_r == ST_ACTIVE && expired && !open_evidence) begin
      failure_latched_r <= 1'b1;
    end else if (lockout_reset) begin
      failure_latched_r <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  property p_trip_on_expiry;
    @(posedge clk_sys) disable iff (rst)
    (in_use && state_r == ST_ACTIVE && expired && !open_evidence) |=> upstream_trip_r && failure_latched_r;
  endproperty
  a_trip_on_expiry: assert property (p_trip_on_expiry) else $error("no trip after expiry");

  property p_reject;
    @(posedge clk_sys) disable iff (rst)
    (in_use && state_r == ST_ACTIVE && open_evidence) |=> state_r == ST_REJECTED && rejected_r;
  endproperty
  a_reject: assert property (p_reject) else $error("stop did not reject");

  property p_idle_unused;
    @(posedge clk_sys) disable iff (rst)
    !in_use |=> state_r == ST_STANDBY && !upstream_trip_r;
  endproperty
  a_idle_unused: assert property (p_idle_unused) else $error("active while unused");

  property p_rej_back;
    @(posedge clk_sys) disable iff (rst)
    (in_use && state_r == ST_REJECTED && !trig_any) |=> state_r == ST_STANDBY;
  endproperty
  a_rej_back: assert property (p_rej_back) else $error("rejected stuck");

  property p_trip_hold;
    @(posedge clk_sys) disable iff (rst)
    (upstream_trip_r && state_r == ST_FAILED && in_use && !(open_evidence && !trig_any)) |=> upstream_trip_r;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip dropped early");

  property p_pos_start;
    @(posedge clk_sys) disable iff (rst)
    (in_use && state_r == ST_STANDBY && scheme == bfs_pkg::BFS_SCH_POS && !brk_s.breaker_closed)
      |=> state_r == ST_STANDBY;
  endproperty
  a_pos_start: assert property (p_pos_start) else $error("start with breaker open");

  property p_unmapped;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_STANDBY && extra_s == '0 && (trip_s & trip_mapped) == '0) |=> state_r == ST_STANDBY;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped trip started");

  property p_latch;
    @(posedge clk_sys) disable iff (rst)
    (failure_latched_r && !lockout_reset) |=> failure_latched_r;
  endproperty
  a_latch: assert property (p_latch) else $error("failure latch lost");

  property p_delay_exact;
    @(posedge clk_sys) disable iff (rst)
    ($rose(run) && fail_delay == 24'h000014)
      |-> !expired [*8] ##1 !expired [*8] ##1 !expired [*4] ##1 (expired || !run);
  endproperty
  a_delay_exact: assert property (p_delay_exact) else $error("expiry count wrong");

  c_fail: cover property (@(posedge clk_sys) disable iff (rst) $rose(upstream_trip_r));
  c_reject: cover property (@(posedge clk_sys) disable iff (rst) $rose(rejected_r));
  c_trip_drop: cover property (@(posedge clk_sys) disable iff (rst) $fell(upstream_trip_r));
endmodule // bfs_supervisor

// file: sim/bfs_brk_model.sv
// contact travel and current model of the monitored breaker
`timescale 1ns/10ps
module bfs_brk_model (
  input wire logic clk_sys, // system clock
  input wire logic open_req, // bench asks breaker to open
  input wire logic uc_req, // bench asks current to fall away
  output bfs_pkg::bfs_breaker_t brk // position and current evidence
);
  // ==========
  // contact travel
  // mid-travel shows neither contact, so the design never sees both at once
  logic [2:0] trav_r = 3'h0;
  logic uc_r = 1'b0;
  always @(posedge clk_sys) begin
    if (open_req && trav_r != 3'h4) begin
      trav_r <= trav_r + 3'h1;
    end else if (!open_req && trav_r != 3'h0) begin
      trav_r <= trav_r - 3'h1;
    end
    uc_r <= uc_req;
  end
  assign brk = {trav_r == 3'h0, trav_r == 3'h4, uc_r};
endmodule // bfs_brk_model

// file: sim/tb.sv
// self-checking bench for the breaker failure supervisor
`timescale 1ns/10ps
module tb;
  // ==========
  // stimulus and design
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic in_use = 1'b1;
  bfs_pkg::bfs_scheme_t scheme = bfs_pkg::BFS_SCH_POS;
  bfs_pkg::bfs_trig_mode_t trig_mode = bfs_pkg::BFS_TRG_ALL;
  logic [23:0] fail_delay = 24'h14;
  logic [7:0] trip_in = 8'h0;
  logic [7:0] trip_mapped = 8'h0;
  logic [7:0] trip_is_current = 8'h0;
  logic [2:0] extra_trigger_input = 3'h0;
  logic open_req = 1'b0;
  logic uc_req = 1'b0;
  logic lockout_reset = 1'b0;
  bfs_pkg::bfs_breaker_t brk_in;
  logic upstream_trip_r;
  logic failure_latched_r;
  logic timer_running_r;
  logic rejected_r;
  logic [1:0] exp_q[$];
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [23:0] lat = 24'h0;
  logic [7:0] b = 8'h1;
  logic trip_d = 1'b0;
  logic rej_d = 1'b0;
  initial forever #5 clk_sys = ~clk_sys;
  bfs_brk_model i_bfs_brk_model (.clk_sys(clk_sys), .open_req(open_req), .uc_req(uc_req), .brk(brk_in));
  bfs_supervisor i_bfs_supervisor (.clk_sys(clk_sys), .rst(rst), .in_use(in_use), .scheme(scheme),
    .trig_mode(trig_mode), .fail_delay(fail_delay), .trip_in(trip_in), .trip_mapped(trip_mapped),
    .trip_is_current(trip_is_current), .extra_trigger_input(extra_trigger_input), .brk_in(brk_in),
    .lockout_reset(lockout_reset), .upstream_trip_r(upstream_trip_r), .failure_latched_r(failure_latched_r),
    .timer_running_r(timer_running_r), .rejected_r(rejected_r));
  // ==========
  // checking and closing
  task automatic check(input logic [23:0] seen, input logic [23:0] expv);
    n_compared++;
    if (seen !== expv) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task end_of_test;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // outcome code: 2 for upstream trip, 1 for rejected
  always @(posedge clk_sys) begin
    trip_d <= upstream_trip_r;
    rej_d <= rejected_r;
    if (!rst && ((upstream_trip_r && !trip_d) || (rejected_r && !rej_d))) begin
      if (exp_q.size() == 0) check({22'h0, upstream_trip_r, rejected_r}, 24'h0);
      else check({22'h0, upstream_trip_r, rejected_r}, {22'h0, exp_q.pop_front()});
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_of_test;
    end
  end
  // ==========
  // one supervision episode; ev is {open before start, open later, current falls later}
  task automatic run(input logic [1:0] sc, input logic [1:0] md, input logic [2:0] ex,
    input logic [1:0] mi, input logic [2:0] ev, input logic [1:0] code);
    int k;
    @(negedge clk_sys);
    scheme = bfs_pkg::bfs_scheme_t'(sc);
    trig_mode = bfs_pkg::bfs_trig_mode_t'(md);
    trip_mapped = mi[1] ? b : ~b;
    trip_is_current = mi[0] ? b : 8'h0;
    open_req = ev[2];
    uc_req = 1'b0;
    repeat (8) @(negedge clk_sys);
    trip_in = (ex == 3'h0) ? b : 8'h0;
    extra_trigger_input = ex;
    if (code == 2'h0) begin
      repeat (40) @(negedge clk_sys);
      check({23'h0, timer_running_r | upstream_trip_r}, 24'h0);
      trip_in = 8'h0;
    end else begin
      exp_q.push_back(code);
      for (k = 0; k < 10 && timer_running_r !== 1'b1; k++) @(negedge clk_sys);
      check({23'h0, timer_running_r}, 24'h1);
      repeat (3) @(negedge clk_sys);
      open_req = ev[2] | ev[1];
      uc_req = ev[0];
      for (k = 3; k < 200 && !(upstream_trip_r || rejected_r); k++) @(negedge clk_sys);
      lat = 24'(k);
      trip_in = 8'h0;
      extra_trigger_input = 3'h0;
      if (upstream_trip_r === 1'b1) begin
        repeat (10) @(negedge clk_sys);
        check({23'h0, upstream_trip_r}, 24'h1);
        open_req = 1'b1;
        uc_req = 1'b1;
      end
      for (k = 0; k < 30 && (upstream_trip_r || rejected_r); k++) @(negedge clk_sys);
      check({22'h0, upstream_trip_r, rejected_r}, 24'h0);
      check({23'h0, failure_latched_r}, {23'h0, code[1]});
      lockout_reset = 1'b1;
      @(negedge clk_sys);
      lockout_reset = 1'b0;
      repeat (2) @(negedge clk_sys);
      check({23'h0, failure_latched_r}, 24'h0);
    end
  endtask
  initial begin
    logic [23:0] lat_a;
    b = 8'($urandom(20905));
    b = 8'h1 << ($urandom % 8);
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    run(2'h0, 2'h0, 3'h0, 2'h3, 3'h0, 2'h2);
    lat_a = lat;
    fail_delay = 24'h28;
    run(2'h0, 2'h0, 3'h0, 2'h3, 3'h0, 2'h2);
    check(lat - lat_a, 24'h14);
    fail_delay = 24'h14;
    run(2'h0, 2'h0, 3'h0, 2'h3, 3'h2, 2'h1);
    run(2'h0, 2'h0, 3'h0, 2'h3, 3'h4, 2'h0);
    run(2'h1, 2'h0, 3'h0, 2'h3, 3'h4, 2'h2);
    run(2'h1, 2'h0, 3'h0, 2'h3, 3'h1, 2'h1);
    run(2'h1, 2'h0, 3'h0, 2'h3, 3'h2, 2'h2);
    run(2'h2, 2'h0, 3'h0, 2'h3, 3'h2, 2'h2);
    run(2'h2, 2'h0, 3'h0, 2'h3, 3'h3, 2'h1);
    run(2'h0, 2'h0, 3'h0, 2'h1, 3'h0, 2'h0);
    run(2'h0, 2'h1, 3'h0, 2'h2, 3'h2, 2'h0);
    run(2'h0, 2'h1, 3'h0, 2'h3, 3'h2, 2'h1);
    run(2'h0, 2'h2, 3'h0, 2'h3, 3'h2, 2'h0);
    run(2'h0, 2'h2, 3'h0, 2'h2, 3'h2, 2'h1);
    run(2'h0, 2'h3, 3'h0, 2'h3, 3'h2, 2'h0);
    run(2'h0, 2'h3, 3'h1 << ($urandom % 3), 2'h1, 3'h2, 2'h1);
    in_use = 1'b0;
    run(2'h0, 2'h0, 3'h0, 2'h3, 3'h0, 2'h0);
    in_use = 1'b1;
    check(24'(exp_q.size()), 24'h0);
    end_of_test;
  end
endmodule // tb
